// ### rtl/eer_defs.svh
// Constants for the serial EEPROM read path
`ifndef EER_DEFS_SVH
`define EER_DEFS_SVH
`define EER_ADDR_W 8
`define EER_MEM_DEPTH 256
`define EER_MEM_FILL 8'h5a
`define EER_DEV_PREAMBLE 4'ha
`define EER_PROT_PREAMBLE 4'h6
`define EER_REV_QUERY 8'h63
`define EER_CORE_PERIOD_NS 25
`define EER_SCL_PERIOD_NS 2500
`define EER_QUARTER_CYCLES (`EER_SCL_PERIOD_NS / (4 * `EER_CORE_PERIOD_NS))
`define EER_BITS_PER_BYTE 4'h8
`endif

// ### rtl/eer_pkg.sv
// Types shared by both ends of the serial EEPROM link
package eer_pkg;
  typedef enum logic [3:0] {
    DS_IDLE, DS_ADDR, DS_WORD, DS_WDATA, DS_ACK, DS_RDATA, DS_RACK, DS_IGNORE
  } eer_dev_st_t;

  typedef enum logic [2:0] {
    MS_IDLE, MS_START, MS_TX, MS_TXACK, MS_RX, MS_RXACK, MS_STOP
  } eer_mst_st_t;

  typedef enum logic [1:0] {
    CMD_CURRENT, CMD_RANDOM, CMD_PERM_QUERY, CMD_REV_QUERY
  } eer_cmd_t;

  typedef struct packed {
    logic sclSync1;
    logic sclSync2;
    logic sclPrev;
    logic sdaSync1;
    logic sdaSync2;
    logic sdaPrev;
    eer_dev_st_t st;
    eer_dev_st_t afterAck;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] wordAddr;
    logic masterAck;
    logic sdaOe;
    logic [2:0] pinSync1;
    logic [2:0] pinSync2;
    logic [1:0] flagSync1;
    logic [1:0] flagSync2;
  } eer_dev_state_t;

  typedef struct packed {
    eer_mst_st_t st;
    eer_cmd_t kind;
    logic [2:0] sel;
    logic [7:0] waddr;
    logic [1:0] seg;
    logic [1:0] q;
    logic [7:0] tick;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] left;
    logic scl;
    logic sdaOe;
    logic sdaSync1;
    logic sdaSync2;
    logic [7:0] rdData;
    logic rdValid;
    logic done;
    logic nackSeen;
    logic cmdReady;
  } eer_mst_state_t;
endpackage : eer_pkg

// ### rtl/eer_link_if.sv
// Two-wire link between bus master and EEPROM device
`timescale 1ns/10ps
interface eer_link_if;
  logic scl;
  logic masterSdaOut;
  logic masterSdaOe;
  logic deviceSdaOut;
  logic deviceSdaOe;
  logic sda;

  // Open drain with pull-up: a low enable pulls the line to the driven value
  assign sda = (masterSdaOe | masterSdaOut) & (deviceSdaOe | deviceSdaOut);

  modport master(output scl, output masterSdaOut, output masterSdaOe, input sda);
  modport device(input scl, output deviceSdaOut, output deviceSdaOe, input sda);
endinterface : eer_link_if

// ### rtl/eer_device.sv
// EEPROM device end: two-wire slave with read path and protect queries
//
// Overview of operation
// - Read bit one in address means read
// - Counter holds last accessed address plus one
// - Counter survives stop and new start
// - Read increment wraps last byte to first
// - Current read: ack, send byte MSB first
// - Master ends single read with nack, stop
// - Random read: write address, restart, read
// - Word address loads counter, no memory write
// - Sequential read follows current or random read
// - Master ack increments, nack releases data
// - Sequential read wraps to zero, continues
// - Permanent query acks only when flag clear
// - Permanent query: preamble, pin bits, read
// - Reversible query acks only when flag clear
// - Protect flags block writes to lower half
`timescale 1ns/10ps
`include "eer_defs.svh"
module eer_device (
  input wire logic core_clk,
  input wire logic rst,
  eer_link_if.device link,
  input wire logic permanent_protect_flag,
  input wire logic reversible_protect_flag,
  input wire logic select_pin_high,
  input wire logic select_pin_mid,
  input wire logic select_pin_low,
  output logic [7:0] wordAddress
);
  import eer_pkg::*;

  eer_dev_state_t s;
  eer_dev_state_t next_s;
  logic [7:0] mem [`EER_MEM_DEPTH];
  logic memWe;
  logic [7:0] memByte;
  logic [2:0] pins;
  logic rise;
  logic fall;
  logic startCond;
  logic stopCond;
  logic writeOk;

  assign pins = s.pinSync2;
  assign memByte = mem[s.wordAddr];
  assign rise = s.sclSync2 & ~s.sclPrev;
  assign fall = ~s.sclSync2 & s.sclPrev;
  assign startCond = s.sclSync2 & s.sclPrev & s.sdaPrev & ~s.sdaSync2;
  assign stopCond = s.sclSync2 & s.sclPrev & ~s.sdaPrev & s.sdaSync2;
  assign writeOk = s.wordAddr[7] | ~(s.flagSync2[1] | s.flagSync2[0]);

  always_comb begin
    next_s = s;
    memWe = 1'b0;
    next_s.sclSync1 = link.scl;
    next_s.sclSync2 = s.sclSync1;
    next_s.sclPrev = s.sclSync2;
    next_s.sdaSync1 = link.sda;
    next_s.sdaSync2 = s.sdaSync1;
    next_s.sdaPrev = s.sdaSync2;
    // Pins and flags come from outside the clock domain
    next_s.pinSync1 = {select_pin_high, select_pin_mid, select_pin_low};
    next_s.pinSync2 = s.pinSync1;
    next_s.flagSync1 = {permanent_protect_flag, reversible_protect_flag};
    next_s.flagSync2 = s.flagSync1;
    if (stopCond) begin
      next_s.st = DS_IDLE;
      next_s.sdaOe = 1'b1;
    end else if (startCond) begin
      next_s.st = DS_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.sdaOe = 1'b1;
    end else begin
      case (s.st)
        DS_ADDR, DS_WORD, DS_WDATA: begin
          if (rise && s.bitCnt != `EER_BITS_PER_BYTE) begin
            next_s.shift = {s.shift[6:0], s.sdaSync2};
            next_s.bitCnt = s.bitCnt + 4'h1;
          end else if (fall && s.bitCnt == `EER_BITS_PER_BYTE) begin
            next_s.st = DS_ACK;
            next_s.sdaOe = 1'b0;
            case (s.st)
              DS_ADDR: begin
                if (s.shift[7:1] == {`EER_DEV_PREAMBLE, pins}) begin
                  next_s.afterAck = s.shift[0] ? DS_RDATA : DS_WORD;
                end else if (s.shift == {`EER_PROT_PREAMBLE, pins, 1'b1}) begin
                  next_s.afterAck = DS_IGNORE;
                  if (s.flagSync2[1]) begin
                    next_s.st = DS_IGNORE;
                    next_s.sdaOe = 1'b1;
                  end
                end else if (s.shift == `EER_REV_QUERY) begin
                  next_s.afterAck = DS_IGNORE;
                  if (s.flagSync2[0]) begin
                    next_s.st = DS_IGNORE;
                    next_s.sdaOe = 1'b1;
                  end
                end else begin
                  next_s.st = DS_IGNORE;
                  next_s.sdaOe = 1'b1;
                end
              end
              DS_WORD: begin
                next_s.wordAddr = s.shift;
                next_s.afterAck = DS_WDATA;
              end
              default: begin
                memWe = writeOk;
                next_s.wordAddr = s.wordAddr + 8'h01;
                next_s.afterAck = DS_WDATA;
              end
            endcase
          end
        end
        DS_ACK: begin
          if (fall) begin
            next_s.bitCnt = 4'h0;
            next_s.st = s.afterAck;
            next_s.sdaOe = 1'b1;
            if (s.afterAck == DS_RDATA) begin
              next_s.shift = memByte;
              next_s.sdaOe = memByte[7];
              next_s.wordAddr = s.wordAddr + 8'h01;
            end
          end
        end
        DS_RDATA: begin
          if (rise) begin
            next_s.bitCnt = s.bitCnt + 4'h1;
          end else if (fall) begin
            if (s.bitCnt == `EER_BITS_PER_BYTE) begin
              next_s.sdaOe = 1'b1;
              next_s.st = DS_RACK;
            end else begin
              // MSB first shift out
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.sdaOe = s.shift[6];
            end
          end
        end
        DS_RACK: begin
          if (rise) begin
            next_s.masterAck = ~s.sdaSync2;
          end else if (fall) begin
            next_s.bitCnt = 4'h0;
            if (s.masterAck) begin
              next_s.st = DS_RDATA;
              next_s.shift = memByte;
              next_s.sdaOe = memByte[7];
              next_s.wordAddr = s.wordAddr + 8'h01;
            end else begin
              next_s.st = DS_IDLE;
              next_s.sdaOe = 1'b1;
            end
          end
        end
        DS_IDLE, DS_IGNORE: begin
          next_s.sdaOe = 1'b1;
        end
        default: begin
          next_s.st = DS_IDLE;
          next_s.sdaOe = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.sclSync1 <= 1'b1;
      s.sclSync2 <= 1'b1;
      s.sclPrev <= 1'b1;
      s.sdaSync1 <= 1'b1;
      s.sdaSync2 <= 1'b1;
      s.sdaPrev <= 1'b1;
      s.st <= DS_IDLE;
      s.afterAck <= DS_IDLE;
      s.sdaOe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Defined content loaded during reset so reads never return unknowns
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `EER_MEM_DEPTH; i++) begin
        mem[i] <= 8'(i) ^ `EER_MEM_FILL;
      end
    end else if (memWe) begin
      mem[s.wordAddr] <= s.shift;
    end
  end

  assign link.deviceSdaOut = 1'b0;
  assign link.deviceSdaOe = s.sdaOe;
  assign wordAddress = s.wordAddr;
endmodule : eer_device

// ### rtl/eer_master.sv
// Bus master end: generates the bus clock and runs read and query commands
`timescale 1ns/10ps
`include "eer_defs.svh"
module eer_master #(
  parameter logic [7:0] QUARTER_CYCLES = 8'(`EER_QUARTER_CYCLES)
) (
  input wire logic core_clk,
  input wire logic rst,
  eer_link_if.master link,
  input wire logic cmdValid,
  input eer_pkg::eer_cmd_t cmdKind,
  input wire logic [2:0] cmdSelect,
  input wire logic [7:0] cmdWordAddr,
  input wire logic [7:0] cmdCount,
  output logic cmdReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done,
  output logic nackSeen
);
  import eer_pkg::*;

  eer_mst_state_t s;
  eer_mst_state_t next_s;
  logic step;
  logic [7:0] firstByte;

  assign step = (s.tick == QUARTER_CYCLES - 8'h01);

  always_comb begin
    case (s.kind)
      CMD_PERM_QUERY: firstByte = {`EER_PROT_PREAMBLE, s.sel, 1'b1};
      CMD_REV_QUERY: firstByte = `EER_REV_QUERY;
      CMD_RANDOM: firstByte = {`EER_DEV_PREAMBLE, s.sel, 1'b0};
      default: firstByte = {`EER_DEV_PREAMBLE, s.sel, 1'b1};
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.sdaSync1 = link.sda;
    next_s.sdaSync2 = s.sdaSync1;
    next_s.rdValid = 1'b0;
    next_s.done = 1'b0;
    if (s.st != MS_IDLE) begin
      next_s.tick = step ? 8'h00 : s.tick + 8'h01;
    end
    if (s.st == MS_IDLE) begin
      next_s.scl = 1'b1;
      next_s.sdaOe = 1'b1;
      if (cmdValid) begin
        next_s.cmdReady = 1'b0;
        next_s.kind = cmdKind;
        next_s.sel = cmdSelect;
        next_s.waddr = cmdWordAddr;
        next_s.left = (cmdCount == 8'h00) ? 8'h01 : cmdCount;
        next_s.seg = 2'h0;
        next_s.q = 2'h0;
        next_s.tick = 8'h00;
        next_s.nackSeen = 1'b0;
        next_s.st = MS_START;
      end
    end else if (step) begin
      next_s.q = s.q + 2'h1;
      case (s.q)
        2'h0: begin
          case (s.st)
            MS_START: next_s.sdaOe = 1'b1;
            MS_TX: next_s.sdaOe = s.shift[7];
            MS_RXACK: next_s.sdaOe = (s.left == 8'h00);
            MS_STOP: next_s.sdaOe = 1'b0;
            default: next_s.sdaOe = 1'b1;
          endcase
        end
        2'h1: next_s.scl = 1'b1;
        2'h2: begin
          case (s.st)
            MS_START: next_s.sdaOe = 1'b0;
            MS_STOP: next_s.sdaOe = 1'b1;
            MS_TXACK: next_s.nackSeen = s.sdaSync2;
            MS_RX: next_s.shift = {s.shift[6:0], s.sdaSync2};
            default: next_s.sdaOe = s.sdaOe;
          endcase
        end
        default: begin
          next_s.scl = (s.st == MS_STOP);
          next_s.bitCnt = s.bitCnt + 4'h1;
          case (s.st)
            MS_START: begin
              next_s.st = MS_TX;
              next_s.bitCnt = 4'h0;
              next_s.shift = (s.seg == 2'h0) ? firstByte : {`EER_DEV_PREAMBLE, s.sel, 1'b1};
            end
            MS_TX: begin
              next_s.shift = {s.shift[6:0], 1'b0};
              if (s.bitCnt == 4'h7) begin
                next_s.st = MS_TXACK;
              end
            end
            MS_TXACK: begin
              next_s.bitCnt = 4'h0;
              if (s.nackSeen || s.kind == CMD_PERM_QUERY || s.kind == CMD_REV_QUERY) begin
                next_s.st = MS_STOP;
              end else if (s.kind == CMD_RANDOM && s.seg == 2'h0) begin
                next_s.st = MS_TX;
                next_s.seg = 2'h1;
                next_s.shift = s.waddr;
              end else if (s.kind == CMD_RANDOM && s.seg == 2'h1) begin
                next_s.st = MS_START;
                next_s.seg = 2'h2;
              end else begin
                next_s.st = MS_RX;
              end
            end
            MS_RX: begin
              if (s.bitCnt == 4'h7) begin
                next_s.st = MS_RXACK;
                next_s.rdData = s.shift;
                next_s.rdValid = 1'b1;
                next_s.left = s.left - 8'h01;
              end
            end
            MS_RXACK: begin
              next_s.bitCnt = 4'h0;
              next_s.st = (s.left == 8'h00) ? MS_STOP : MS_RX;
            end
            default: begin
              next_s.st = MS_IDLE;
              next_s.done = 1'b1;
              next_s.cmdReady = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= MS_IDLE;
      s.kind <= CMD_CURRENT;
      s.scl <= 1'b1;
      s.sdaOe <= 1'b1;
      s.sdaSync1 <= 1'b1;
      s.sdaSync2 <= 1'b1;
      s.cmdReady <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.scl = s.scl;
  assign link.masterSdaOut = 1'b0;
  assign link.masterSdaOe = s.sdaOe;
  assign cmdReady = s.cmdReady;
  assign rdData = s.rdData;
  assign rdValid = s.rdValid;
  assign done = s.done;
  assign nackSeen = s.nackSeen;
endmodule : eer_master

// ### test/eer_link_props.sv
// Protocol checks on the two-wire link between master and device
`timescale 1ns/10ps
module eer_link_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic masterSdaOut,
  input wire logic masterSdaOe,
  input wire logic deviceSdaOut,
  input wire logic deviceSdaOe,
  input wire logic sda
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_ADDR_QUIET: assert property ((scl && $fell(sda)) |=> deviceSdaOe [*8])
    else $error("device drove sda during address byte");
  AST_IDLE_RESET: assert property ($fell(rst) |-> scl && sda)
    else $error("bus not idle after reset");
  AST_ACK_HOLD: assert property (($rose(scl) && !deviceSdaOe) |-> !deviceSdaOe [*8])
    else $error("device released sda during high clock");
  AST_STOP_FREE: assert property ((scl && $rose(sda)) |=> (scl && deviceSdaOe) [*4])
    else $error("device drives after stop");
  AST_START_SCL: assert property ((scl && $fell(sda)) |-> ##[1:300] !scl)
    else $error("no clock after start");
  AST_DEV_EDGE: assert property ($changed(deviceSdaOe) |-> !scl && !$past(scl))
    else $error("device changed sda while clock high");
  // clock high long enough to sample
  AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*8])
    else $error("bus clock high phase too short");
  // clock low long enough for device
  AST_SCL_LOW: assert property ($fell(scl) |=> !scl [*8])
    else $error("bus clock low phase too short");

  COV_ACK: cover property ($rose(scl) && !deviceSdaOe);
  COV_STOP: cover property (scl && $rose(sda));
  COV_START: cover property (scl && $fell(sda));
endmodule : eer_link_props

// ### test/serial_eeprom_read_path_bench.sv
// Self-checking bench joining master and device ends
`timescale 1ns/10ps
`include "eer_defs.svh"
module serial_eeprom_read_path_bench;
  import eer_pkg::*;
  localparam logic [7:0] QC = 8'h05;
  logic core_clk, rst, cmdValid, cmdReady, rdValid, done, nackSeen, permFlag, revFlag;
  logic [2:0] pins, cmdSelect;
  eer_cmd_t cmdKind;
  logic [7:0] cmdWordAddr, cmdCount, rdData, wordAddress, ctr;
  int miscompares, compares, cycles, rdSeen;
  logic [8:0] expQ[$];
  int cntQ[$];
  logic [7:0] dataQ[$];

  eer_link_if i_eer_link_if();
  eer_master #(.QUARTER_CYCLES(QC)) i_eer_master (.core_clk(core_clk), .rst(rst), .link(i_eer_link_if.master),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdSelect(cmdSelect), .cmdWordAddr(cmdWordAddr),
    .cmdCount(cmdCount), .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid), .done(done),
    .nackSeen(nackSeen));
  eer_device i_eer_device (.core_clk(core_clk), .rst(rst), .link(i_eer_link_if.device),
    .permanent_protect_flag(permFlag), .reversible_protect_flag(revFlag), .select_pin_high(pins[2]),
    .select_pin_mid(pins[1]), .select_pin_low(pins[0]), .wordAddress(wordAddress));
  eer_link_props i_eer_link_props (.core_clk(core_clk), .rst(rst), .scl(i_eer_link_if.scl),
    .masterSdaOut(i_eer_link_if.masterSdaOut), .masterSdaOe(i_eer_link_if.masterSdaOe),
    .deviceSdaOut(i_eer_link_if.deviceSdaOut), .deviceSdaOe(i_eer_link_if.deviceSdaOe),
    .sda(i_eer_link_if.sda));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end

  // Result watcher, sampled away from the launching edge
  always @(negedge core_clk) begin
    if (rdValid === 1'b1) begin
      rdSeen++;
      check({1'b0, rdData}, {1'b0, dataQ.pop_front()});
    end
    if (done === 1'b1) begin
      check({nackSeen, wordAddress}, expQ.pop_front());
      check(9'(rdSeen), 9'(cntQ.pop_front()));
      rdSeen = 0;
    end
  end

  task automatic run(input eer_cmd_t k, input logic [2:0] sel, input logic [7:0] wa, input logic [7:0] n,
                     input logic nack, input int nb);
    expQ.push_back({nack, ctr});
    cntQ.push_back(nb);
    cmdKind = k;
    cmdSelect = sel;
    cmdWordAddr = wa;
    cmdCount = n;
    cmdValid = 1'b1;
    @(posedge core_clk);
    #2 cmdValid = 1'b0;
    while (cmdReady !== 1'b1) begin
      @(posedge core_clk);
      #2;
    end
  endtask : run

  task automatic rd(input eer_cmd_t k, input logic [7:0] wa, input logic [7:0] n);
    int nb;
    nb = (n == 8'h00) ? 1 : int'(n);
    if (k == CMD_RANDOM) begin
      ctr = wa;
    end
    for (int j = 0; j < nb; j++) begin
      dataQ.push_back((ctr + 8'(j)) ^ `EER_MEM_FILL);
    end
    ctr = ctr + 8'(nb);
    run(k, pins, wa, n, 1'b0, nb);
  endtask : rd

  initial begin
    cmdValid = 1'b0;
    cmdKind = CMD_CURRENT;
    cmdSelect = 3'h0;
    cmdWordAddr = 8'h00;
    cmdCount = 8'h00;
    permFlag = 1'b0;
    revFlag = 1'b0;
    rst = 1'b1;
    ctr = 8'h00;
    void'($urandom(85));
    pins = 3'($urandom);
    repeat (20) @(posedge core_clk);
    #2 rst = 1'b0;
    @(posedge core_clk);
    #2;
    rd(CMD_CURRENT, 8'h00, 8'h01);
    rd(CMD_RANDOM, 8'hfe, 8'h04);
    rd(CMD_CURRENT, 8'h00, 8'h02);
    rd(CMD_RANDOM, 8'hff, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(CMD_RANDOM, 8'($urandom), 8'(1 + $urandom % 4));
    end
    run(CMD_CURRENT, pins ^ 3'h1, 8'h00, 8'h01, 1'b1, 0);
    for (int i = 0; i < 4; i++) begin
      permFlag = i[0];
      revFlag = i[1];
      run(CMD_PERM_QUERY, pins, 8'h00, 8'h00, permFlag, 0);
      run(CMD_REV_QUERY, pins, 8'h00, 8'h00, revFlag, 0);
    end
    rd(CMD_CURRENT, 8'h00, 8'h03);
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule : serial_eeprom_read_path_bench
